// ---- design/dsw_port_ctrl.sv ----
// Purpose: Host-side controller driving one port of an async dual-port SRAM
// Assumes: Device pins are asynchronous; read data are synchronised by two flops
// Notes:   Every write is write-line controlled with output enable held high
//
// Operation
// - The controller holds chip select low with flag select high for the array, and the reverse for a flag, steady through the cycle.
// - The address changes only while the write line is high, chip select is high or both lanes are off.
// - The controller drives no write data while the device may still be driving the data pins.
// - Across a flag write and its read-back, chip select stays high.
`timescale 1ns/100ps
`default_nettype none
module dsw_port_ctrl (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   // User request
   input  wire logic                       req_valid,
   output logic                            req_ready,
   input  wire dsw_pkg::dsw_req_s          req,
   // User answer
   output logic                            rsp_valid,
   output logic [dsw_pkg::DATA_W-1:0]      rsp_data,
   output logic                            rsp_flag,
   // Device pins
   output dsw_pkg::dsw_pins_s              pins,
   input  wire logic [dsw_pkg::DATA_W-1:0] data_pins_i,
   output logic [dsw_pkg::DATA_W-1:0]      data_pins_o,
   output logic [dsw_pkg::DATA_W-1:0]      data_pins_oe
);
   import dsw_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WR_OFF,
      ST_WR_DATA,
      ST_WR_REC,
      ST_RD_WAIT,
      ST_RD_DONE,
      ST_RD_OFF
   } dsw_state_e;

   dsw_state_e             state_r;
   dsw_req_s               cur_r;
   dsw_pins_s              pins_r;
   logic [DATA_W-1:0]      wdata_r;
   logic [DATA_W-1:0]      oe_r;
   logic [DATA_W-1:0]      sync1_r;
   logic [DATA_W-1:0]      sync2_r;
   logic [DATA_W-1:0]      rsp_data_r;
   logic                   rsp_flag_r;
   logic                   rsp_valid_r;
   logic                   cnt_load;
   logic [CNT_W-1:0]       cnt_val;
   logic                   cnt_done;
   logic                   is_flag;
   logic [DATA_W-1:0]      lane_mask;

   dsw_delay_cnt u_cnt (
      .clk      (clk),
      .rst_b    (rst_b),
      .load     (cnt_load),
      .load_val (cnt_val),
      .done     (cnt_done)
   );

   assign is_flag  = (cur_r.op == DSW_OP_WR_FLAG) || (cur_r.op == DSW_OP_RD_FLAG);
   assign req_ready = (state_r == ST_IDLE);

   // Lane masks for the data drivers
   genvar gi;
   generate
      for (gi = 0; gi < DATA_W; gi++) begin : g_lane
         assign lane_mask[gi] = (gi >= 8) ? cur_r.lane_en[1] : cur_r.lane_en[0];
      end
   endgenerate

   // Two flops before any logic looks at the data pins
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sync1_r <= DATA_RST;
         sync2_r <= DATA_RST;
      end else begin
         sync1_r <= data_pins_i;
         sync2_r <= sync1_r;
      end
   end

   // Sequencer and phase timer loads
   always_comb begin
      cnt_load = 1'b0;
      cnt_val  = '0;
      case (state_r)
         ST_IDLE: begin
            if (req_valid) begin
               cnt_load = 1'b1;
               if ((req.op == DSW_OP_WR_ARRAY) || (req.op == DSW_OP_WR_FLAG)) begin
                  cnt_val = CNT_W'(WZ_CYC);
               end else if (req.op == DSW_OP_RD_FLAG) begin
                  cnt_val = CNT_W'(SAA_CYC + SWRD_CYC);
               end else begin
                  cnt_val = CNT_W'(AA_CYC);
               end
            end
         end
         ST_WR_OFF: begin
            if (cnt_done) begin
               cnt_load = 1'b1;
               cnt_val  = CNT_W'((WP_CYC > DW_CYC) ? WP_CYC : DW_CYC);
            end
         end
         ST_WR_DATA: begin
            if (cnt_done) begin
               cnt_load = 1'b1;
               cnt_val  = CNT_W'(WR_CYC);
            end
         end
         ST_RD_DONE: begin
            cnt_load = 1'b1;
            cnt_val  = CNT_W'(HZ_CYC);
         end
         default: begin
            cnt_load = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE:    if (req_valid) state_r <= ((req.op == DSW_OP_WR_ARRAY) || (req.op == DSW_OP_WR_FLAG))
                                                  ? ST_WR_OFF : ST_RD_WAIT;
            ST_WR_OFF:  if (cnt_done) state_r <= ST_WR_DATA;
            ST_WR_DATA: if (cnt_done) state_r <= ST_WR_REC;
            ST_WR_REC:  if (cnt_done) state_r <= ST_IDLE;
            ST_RD_WAIT: if (cnt_done) state_r <= ST_RD_DONE;
            ST_RD_DONE: state_r <= ST_RD_OFF;
            ST_RD_OFF:  if (cnt_done) state_r <= ST_IDLE;
            default:    state_r <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cur_r <= '0;
      end else if ((state_r == ST_IDLE) && req_valid) begin
         cur_r <= req;
      end
   end

   // Pin drive: address set in idle, selects in the next state, write line dropped first
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pins_r <= '{addr: ADDR_RST, default: 1'b1};
      end else begin
         case (state_r)
            ST_IDLE: begin
               pins_r <= '{addr: pins_r.addr, default: 1'b1};
               if (req_valid) begin
                  pins_r.addr <= req.addr;
                  // Write line goes low before the selects; device outputs stay off
                  pins_r.rw_n <= !((req.op == DSW_OP_WR_ARRAY) || (req.op == DSW_OP_WR_FLAG));
                  pins_r.out_en_n <= (req.op == DSW_OP_WR_ARRAY) || (req.op == DSW_OP_WR_FLAG);
               end
            end
            ST_WR_OFF, ST_RD_WAIT: begin
               pins_r.chip_sel_n    <= is_flag;
               pins_r.flag_select_n <= !is_flag;
               pins_r.upper_lane_en_n <= is_flag ? 1'b1 : !cur_r.lane_en[1];
               pins_r.lower_lane_en_n <= is_flag ? 1'b1 : !cur_r.lane_en[0];
            end
            ST_WR_DATA: begin
               // Write line rises first and ends the cycle with selects still low
               if (cnt_done) pins_r.rw_n <= 1'b1;
            end
            ST_WR_REC, ST_RD_DONE: begin
               pins_r.chip_sel_n      <= 1'b1;
               pins_r.flag_select_n   <= 1'b1;
               pins_r.upper_lane_en_n <= 1'b1;
               pins_r.lower_lane_en_n <= 1'b1;
               pins_r.out_en_n        <= 1'b1;
            end
            default: begin
               pins_r.rw_n <= 1'b1;
            end
         endcase
      end
   end

   // Write data only after the device's drivers have had time to turn off
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         oe_r    <= '0;
         wdata_r <= DATA_RST;
      end else if (state_r == ST_WR_OFF && cnt_done) begin
         oe_r    <= is_flag ? {DATA_W{1'b1}} : lane_mask;
         wdata_r <= cur_r.wdata;
      end else if (state_r == ST_WR_REC && cnt_done) begin
         oe_r    <= '0;
      end
   end

   // Answer capture; a flag read takes bit 0 as the flag, all bits should agree
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rsp_valid_r <= 1'b0;
         rsp_data_r  <= DATA_RST;
         rsp_flag_r  <= 1'b1;
      end else begin
         rsp_valid_r <= 1'b0;
         if (state_r == ST_RD_DONE) begin
            rsp_valid_r <= 1'b1;
            rsp_data_r  <= sync2_r & (is_flag ? {DATA_W{1'b1}} : lane_mask);
            rsp_flag_r  <= sync2_r[0];
         end else if ((state_r == ST_WR_REC) && cnt_done) begin
            rsp_valid_r <= 1'b1;
         end
      end
   end

   assign pins         = pins_r;
   assign data_pins_o  = wdata_r;
   assign data_pins_oe = oe_r;
   assign rsp_valid    = rsp_valid_r;
   assign rsp_data     = rsp_data_r;
   assign rsp_flag     = rsp_flag_r;
endmodule : dsw_port_ctrl
`default_nettype wire

// ---- inc/dsw_pkg.sv ----
// Purpose: Shared constants and carrier types for the dual-port SRAM port controller
// Assumes: 25 MHz clock, 40 ns period; slowest speed grade timing figures
// Notes:   Times in ns, cycle counts derived and rounded per min/max sense
package dsw_pkg;
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned ADDR_W        = 15;
   localparam int unsigned DATA_W        = 16;
   localparam int unsigned FLAG_ADDR_W   = 3;
   localparam int unsigned T_WP_NS       = 40;   // Write pulse width, min
   localparam int unsigned T_WZ_NS       = 25;   // Write enable to output high-Z, max
   localparam int unsigned T_DW_NS       = 30;   // Data valid to end of write, min
   localparam int unsigned T_WR_NS       = 0;    // Write recovery, min
   localparam int unsigned T_SWRD_NS     = 5;    // Flag write to read, min
   localparam int unsigned T_SAA_NS      = 55;   // Flag read access, max wait
   localparam int unsigned T_AA_NS       = 55;   // Array read access
   localparam int unsigned T_HZ_NS       = 25;   // Output turn-off after read

   function automatic int unsigned cyc_min(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_min

   // Least times round up; a wait for access also rounds up to be safe
   localparam int unsigned WP_CYC   = cyc_min(T_WP_NS);
   localparam int unsigned WZ_CYC   = cyc_min(T_WZ_NS);
   localparam int unsigned DW_CYC   = cyc_min(T_DW_NS);
   localparam int unsigned WR_CYC   = cyc_min(T_WR_NS);
   localparam int unsigned SWRD_CYC = cyc_min(T_SWRD_NS);
   localparam int unsigned SAA_CYC  = cyc_min(T_SAA_NS);
   localparam int unsigned AA_CYC   = cyc_min(T_AA_NS);
   localparam int unsigned HZ_CYC   = cyc_min(T_HZ_NS);
   localparam int unsigned CNT_W    = 4;

   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;

   typedef enum logic [1:0] {
      DSW_OP_WR_ARRAY,
      DSW_OP_RD_ARRAY,
      DSW_OP_WR_FLAG,
      DSW_OP_RD_FLAG
   } dsw_op_e;

   // User request
   typedef struct packed {
      dsw_op_e             op;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
      logic [1:0]          lane_en;   // [1] upper, [0] lower, active high
   } dsw_req_s;

   // Pins driven toward the memory port, all strobes active-low as on the part
   typedef struct packed {
      logic [ADDR_W-1:0]   addr;
      logic                chip_sel_n;
      logic                flag_select_n;
      logic                rw_n;
      logic                out_en_n;
      logic                upper_lane_en_n;
      logic                lower_lane_en_n;
   } dsw_pins_s;
endpackage : dsw_pkg

// ---- design/dsw_delay_cnt.sv ----
// Purpose: Down counter that times each phase of a port cycle
// Assumes: Load and count on the same clock as the controller
// Notes:   done is high while the count is zero
`timescale 1ns/100ps
`default_nettype none
module dsw_delay_cnt (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   // Control
   input  wire logic                     load,
   input  wire logic [dsw_pkg::CNT_W-1:0] load_val,
   // Status
   output logic                          done
);
   import dsw_pkg::*;

   logic [CNT_W-1:0] cnt_r;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt_r <= '0;
      end else if (load) begin
         cnt_r <= load_val;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   assign done = (cnt_r == '0);
endmodule : dsw_delay_cnt
`default_nettype wire

// ---- verification/dsw_asserts.sv ----
// Purpose: Pin protocol checks for the port controller
// Assumes: One clock domain, synchronous reset
// Notes:   Device-side behaviour is judged by the memory model
`timescale 1ns/100ps
`default_nettype none
module dsw_asserts (
   // Clock and reset
   input wire logic                       clk,
   input wire logic                       rst_b,
   // User side
   input wire logic                       req_valid,
   input wire logic                       req_ready,
   input wire dsw_pkg::dsw_req_s          req,
   input wire logic                       rsp_valid,
   // Pins
   input wire dsw_pkg::dsw_pins_s         pins,
   input wire logic [dsw_pkg::DATA_W-1:0] data_pins_oe
);
   import dsw_pkg::*;
   wire inh = pins.rw_n | pins.chip_sel_n | (pins.upper_lane_en_n & pins.lower_lane_en_n);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   AST_ARRAY_SEL: assert property (!pins.chip_sel_n |-> pins.flag_select_n)
      else $error("both selects low");
   AST_SEL_HOLD: assert property (
      !pins.rw_n && $past(!pins.rw_n) && $past(!pins.chip_sel_n || !pins.flag_select_n)
      |-> $stable(pins.chip_sel_n) && $stable(pins.flag_select_n))
      else $error("select changed in write");
   AST_ADDR_HOLD: assert property ($changed(pins.addr) |-> inh && $past(inh))
      else $error("address moved while writing");
   AST_NO_DRIVE: assert property (|data_pins_oe |-> pins.out_en_n && $past(pins.out_en_n))
      else $error("data driven against device");
   AST_FLAG_LANES: assert property (!pins.flag_select_n |->
      pins.chip_sel_n && pins.upper_lane_en_n && pins.lower_lane_en_n)
      else $error("flag cycle with array enables");
   AST_RW_FIRST: assert property ($fell(pins.rw_n) |-> pins.chip_sel_n && pins.flag_select_n)
      else $error("select fell before write line");
   AST_RW_LAST: assert property (
      ($rose(pins.chip_sel_n) || $rose(pins.flag_select_n)) |-> pins.rw_n && $past(pins.rw_n))
      else $error("select rose before write line");
   // Turnaround is fixed by the phase counts: write 6, array read 4, flag read 5 cycles
   AST_ANSWER_WR: assert property (
      req_valid && req_ready && (req.op == DSW_OP_WR_ARRAY || req.op == DSW_OP_WR_FLAG)
      |=> !rsp_valid [*6] ##1 rsp_valid)
      else $error("write answer late or early");
   AST_ANSWER_RD: assert property (
      req_valid && req_ready && (req.op == DSW_OP_RD_ARRAY) |=> !rsp_valid [*4] ##1 rsp_valid)
      else $error("array read answer late or early");
   AST_ANSWER_FLAG: assert property (
      req_valid && req_ready && (req.op == DSW_OP_RD_FLAG) |=> !rsp_valid [*5] ##1 rsp_valid)
      else $error("flag read answer late or early");
endmodule : dsw_asserts
bind dsw_port_ctrl dsw_asserts u_chk (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
   .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .pins(pins), .data_pins_oe(data_pins_oe));
`default_nettype wire

// ---- verification/dsw_mem_model.sv ----
// Purpose: Behavioural model of one memory port
// Assumes: 256 words and 8 flags; upper address bits alias
// Notes:   Undriven bits show inverted data so stale values never pass
`timescale 1ns/100ps
`default_nettype none
module dsw_mem_model #(
   parameter int ACC_NS = 10
) (
   // Controller side
   input  wire dsw_pkg::dsw_pins_s         pins,
   input  wire logic [dsw_pkg::DATA_W-1:0] data_pins_o,
   input  wire logic [dsw_pkg::DATA_W-1:0] data_pins_oe,
   // Flags held by the far port
   input  wire logic [7:0]                 other_own,
   // Resolved bus
   output logic [dsw_pkg::DATA_W-1:0]      data_pins_i
);
   import dsw_pkg::*;
   logic [15:0] mem [0:255];
   logic [7:0]  flag;
   logic [15:0] rdv;
   logic [15:0] dly;
   wire [15:0] lane = {{8{!pins.upper_lane_en_n}}, {8{!pins.lower_lane_en_n}}};
   wire wr_arr = !pins.chip_sel_n && !pins.rw_n;
   wire wr_flg = !pins.flag_select_n && !pins.rw_n;
   wire rd_en = !pins.out_en_n && pins.rw_n && (pins.chip_sel_n != pins.flag_select_n);
   initial begin
      foreach (mem[i]) mem[i] = 16'h0000;
      flag = 8'hFF;
   end
   always @* rdv = !pins.flag_select_n ? {16{flag[pins.addr[2:0]]}} : mem[pins.addr[7:0]];
   always @(rdv) dly <= #ACC_NS rdv;
   always @* for (int i = 0; i < 16; i++) data_pins_i[i] = data_pins_oe[i] ? data_pins_o[i] :
      (rd_en && (lane[i] || !pins.flag_select_n)) ? dly[i] : ~dly[i];
   // Write lands at the first rising strobe
   always @(negedge wr_arr) for (int i = 0; i < 16; i++) if (lane[i]) mem[pins.addr[7:0]][i] = data_pins_i[i];
   // A claim held by the far port is refused
   always @(negedge wr_flg) begin
      if (data_pins_i[0]) flag[pins.addr[2:0]] = 1'b1;
      else if (!other_own[pins.addr[2:0]]) flag[pins.addr[2:0]] = 1'b0;
   end
endmodule : dsw_mem_model
`default_nettype wire

// ---- verification/dual_port_sram_write_semaphore_test.sv ----
// Purpose: Self-checking bench for the port controller
// Assumes: Fixed seed; model holds 256 words and 8 flags
// Notes:   Expected array data come from a shadow copy in the bench; flag results are expected from other_own
`timescale 1ns/100ps
`default_nettype none
module dual_port_sram_write_semaphore_test;
   import dsw_pkg::*;
   logic        clk;
   logic        rst_b;
   logic        req_valid;
   logic        req_ready;
   dsw_req_s    req;
   logic        rsp_valid;
   logic [15:0] rsp_data;
   logic        rsp_flag;
   dsw_pins_s   pins;
   logic [15:0] dp_i;
   logic [15:0] dp_o;
   logic [15:0] dp_oe;
   logic [7:0]  other_own;
   logic [15:0] shadow [0:255];
   logic [14:0] ta;
   logic [15:0] td;
   logic [1:0]  tl;
   int          bad_count;
   int          tests_run;
   int          seed;
   dsw_port_ctrl u_dut (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready), .req(req),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_flag(rsp_flag), .pins(pins), .data_pins_i(dp_i),
      .data_pins_o(dp_o), .data_pins_oe(dp_oe));
   dsw_mem_model #(.ACC_NS(55)) u_mem (.pins(pins), .data_pins_o(dp_o), .data_pins_oe(dp_oe),
      .other_own(other_own), .data_pins_i(dp_i));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   function automatic logic [15:0] lane_mask(input logic [1:0] ln);
      return {{8{ln[1]}}, {8{ln[0]}}};
   endfunction : lane_mask
   task automatic do_op(input dsw_op_e o, input logic [14:0] a, input logic [15:0] d, input logic [1:0] ln);
      int n;
      n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{op: o, addr: a, wdata: d, lane_en: ln};
      do begin
         @(negedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 50);
      // A request never taken falls through to the timeout below
      if (req_ready === 1'b1) begin
         @(posedge clk);
         req_valid <= 1'b0;
         do begin
            @(negedge clk);
            n++;
         end while (rsp_valid !== 1'b1 && n < 80);
      end
      if (rsp_valid !== 1'b1) begin
         bad_count++;
         results();
      end
   endtask : do_op
   initial begin
      seed = 32'h41DFB7C7;
      rst_b = 1'b0;
      req_valid = 1'b0;
      req = '0;
      other_own = 8'h00;
      foreach (shadow[i]) shadow[i] = 16'h0000;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      check("idle strobes", {10'h000, pins.chip_sel_n, pins.flag_select_n, pins.rw_n, pins.out_en_n,
         pins.upper_lane_en_n, pins.lower_lane_en_n}, 16'h003F);
      check("idle drive", dp_oe, 16'h0000);
      $display("test reset done");
      for (int k = 0; k < 40; k++) begin
         ta = 15'($random(seed));
         td = 16'($random(seed));
         tl = (k < 4) ? 2'(k) : 2'($random(seed));
         do_op(DSW_OP_WR_ARRAY, ta, td, tl);
         shadow[ta[7:0]] = (shadow[ta[7:0]] & ~lane_mask(tl)) | (td & lane_mask(tl));
         // Odd passes read through an alias of the same word
         if (k[0]) ta[14:8] = ~ta[14:8];
         tl = 2'($random(seed));
         do_op(DSW_OP_RD_ARRAY, ta, 16'h0000, tl);
         check("array read", rsp_data, shadow[ta[7:0]] & lane_mask(tl));
      end
      $display("test array done");
      other_own = 8'($random(seed));
      for (int f = 0; f < 8; f++) begin
         do_op(DSW_OP_WR_FLAG, 15'(f), 16'h0000, 2'b00);
         do_op(DSW_OP_RD_FLAG, 15'(f), 16'h0000, 2'b00);
         check("flag claim", {15'h0000, rsp_flag}, {15'h0000, other_own[f]});
         check("flag claim word", rsp_data, {16{other_own[f]}});
         do_op(DSW_OP_WR_FLAG, 15'(f), 16'hFFFF, 2'b11);
         do_op(DSW_OP_RD_FLAG, 15'(f), 16'h0000, 2'b11);
         check("flag release", {15'h0000, rsp_flag}, 16'h0001);
         check("flag release word", rsp_data, 16'hFFFF);
      end
      $display("test flags done");
      results();
   end
endmodule : dual_port_sram_write_semaphore_test
`default_nettype wire
